// [rtl/pmmp_if.sv]
// Pin bundle between the PHY end and the MAC end.
// Resolves the shared management data wire; idle level is the pull-up.
interface pmmp_if;
    logic       tx_clk;
    logic       gtx_clk;
    logic       rx_clk;
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
    logic [7:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
    logic       mdc;
    logic       mac_mdio_o;
    logic       mac_mdio_oe_b;
    logic       phy_mdio_o;
    logic       phy_mdio_oe_b;
    logic       mdio;

    // Pull-up wins when nobody drives
    assign mdio = !mac_mdio_oe_b ? mac_mdio_o : (!phy_mdio_oe_b ? phy_mdio_o : 1'b1);

    modport phy (
        input  gtx_clk, txd, tx_en, tx_er, mdc, mdio,
        output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, phy_mdio_o, phy_mdio_oe_b
    );

    modport mac (
        input  tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio,
        output gtx_clk, txd, tx_en, tx_er, mdc, mac_mdio_o, mac_mdio_oe_b
    );
endinterface

// [rtl/pmmp_mac_end.sv]
// MAC end of the MII/GMII port: gigabit and management clocks, transmit drive.
// Runs on the reference clock; pins from the PHY pass two flops first.
module pmmp_mac_end (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    input  wire pmmp_pkg::pmmp_speed_t i_speed,
    input  wire logic                  i_tx_valid,
    input  wire logic [7:0]            i_tx_data,
    input  wire logic                  i_tx_err,
    output logic                       o_tx_ready,
    output logic                       o_rx_valid,
    output logic [7:0]                 o_rx_data,
    output logic                       o_rx_err,
    output logic                       o_crs,
    output logic                       o_col,
    input  wire logic                  i_mgmt_drive,
    input  wire logic                  i_mgmt_bit,
    output logic                       o_mgmt_bit,
    pmmp_if.mac                        link
);
    import pmmp_pkg::*;

    logic [7:0]  gtx_div_q;
    logic        gtx_q;
    logic        gtx_fall;
    logic [7:0]  mdc_div_q;
    logic        mdc_q;
    logic [14:0] pin_meta_q;
    logic [14:0] pin_sync_q;
    logic        txc_prev_q;
    logic        rxc_prev_q;
    logic        s_txc;
    logic        s_rxc;
    logic        s_mdio;
    logic        s_dv;
    logic        s_er;
    logic        s_crs;
    logic        s_col;
    logic [7:0]  s_rxd;
    logic        tx_step;
    logic        rx_take;
    logic [7:0]  txd_q;
    logic        tx_en_q;
    logic        tx_er_q;
    logic        rx_valid_q;
    logic [7:0]  rx_data_q;
    logic        rx_err_q;
    logic        mdio_o_q;
    logic        mdio_oe_b_q;

    // RQ9 continuous gigabit transmit clock
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gtx_div_q <= 8'h00;
            gtx_q     <= 1'b0;
        end else if (gtx_div_q == PMMP_GTX_HALF - 8'h01) begin
            gtx_div_q <= 8'h00;
            gtx_q     <= ~gtx_q;
        end else begin
            gtx_div_q <= gtx_div_q + 8'h01;
        end
    end

    assign gtx_fall     = (gtx_div_q == PMMP_GTX_HALF - 8'h01) && gtx_q;
    assign link.gtx_clk = gtx_q;

    // RQ1 management clock no faster than limit
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mdc_div_q <= 8'h00;
            mdc_q     <= 1'b0;
        end else if (mdc_div_q == PMMP_MDC_HALF - 8'h01) begin
            mdc_div_q <= 8'h00;
            mdc_q     <= ~mdc_q;
        end else begin
            mdc_div_q <= mdc_div_q + 8'h01;
        end
    end

    assign link.mdc = mdc_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta_q <= 15'h0000;
            pin_sync_q <= 15'h0000;
        end else begin
            pin_meta_q <= {link.tx_clk, link.rx_clk, link.mdio, link.rx_dv, link.rx_er,
                           link.crs, link.col, link.rxd};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign {s_txc, s_rxc, s_mdio, s_dv, s_er, s_crs, s_col, s_rxd} = pin_sync_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            txc_prev_q <= 1'b0;
            rxc_prev_q <= 1'b0;
        end else begin
            txc_prev_q <= s_txc;
            rxc_prev_q <= s_rxc;
        end
    end

    // RQ17 change lines on the gigabit falling edge; at 10/100 after the synchronised tx_clk rise
    assign tx_step    = (i_speed == PMMP_SPD_1000) ? gtx_fall : (s_txc && !txc_prev_q);
    assign rx_take    = s_rxc && !rxc_prev_q;
    assign o_tx_ready = tx_step;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            txd_q   <= 8'h00;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end else if (tx_step) begin
            // RQ7 nibble or byte lanes
            txd_q   <= i_tx_valid ? pmmp_lane(i_tx_data, i_speed) : 8'h00;
            // RQ8 enable marks each word
            tx_en_q <= i_tx_valid;
            // RQ10 error not driven at 10 Mb/s
            tx_er_q <= i_tx_valid && i_tx_err && (i_speed != PMMP_SPD_10);
        end
    end

    assign link.txd   = txd_q;
    assign link.tx_en = tx_en_q;
    assign link.tx_er = tx_er_q;

    // RQ15 keep only words marked valid
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_err_q   <= 1'b0;
        end else begin
            rx_valid_q <= rx_take && s_dv;
            if (rx_take) begin
                rx_data_q <= pmmp_lane(s_rxd, i_speed);
                rx_err_q  <= s_er;
            end
        end
    end

    assign o_rx_valid = rx_valid_q;
    assign o_rx_data  = rx_data_q;
    assign o_rx_err   = rx_err_q;
    assign o_crs      = s_crs;
    assign o_col      = s_col;

    // RQ2 release line unless driving
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mdio_o_q    <= 1'b1;
            mdio_oe_b_q <= 1'b1;
        end else begin
            mdio_o_q    <= i_mgmt_bit;
            mdio_oe_b_q <= !i_mgmt_drive;
        end
    end

    assign link.mac_mdio_o    = mdio_o_q;
    assign link.mac_mdio_oe_b = mdio_oe_b_q;
    assign o_mgmt_bit         = s_mdio;

endmodule

// [rtl/pmmp_phy_end.sv]
// PHY end of the MII/GMII port: clocks, receive drive, transmit capture.
// Runs on the link clock; all pins from the MAC pass a two-flop synchroniser.
//
// Notes on behaviour
// RQ1 - Management clock at most 2.5 MHz
// RQ2 - Each party releases shared management data line
// RQ3 - Half duplex: carrier on receive or transmit
// RQ4 - Full duplex: carrier only receive, gigabit low
// RQ5 - Collision on overlap in half duplex only
// RQ6 - PHY drives continuous transmit clock at 10/100
// RQ7 - MAC sends nibbles or bytes per mode
// RQ8 - Transmit data accepted only while enable high
// RQ9 - MAC sources continuous gigabit transmit clock
// RQ10 - Transmit error only at 100 or gigabit
// RQ11 - Nibble error: invalid then halt symbols
// RQ12 - Gigabit error: emit error code-group
// RQ13 - PHY drives receive clock for each speed
// RQ14 - Receive data nibbles or bytes per mode
// RQ15 - Receive valid qualifies each received word
// RQ16 - Receive error at 100 or gigabit only
// RQ17 - Sample on rising edge, change on falling; at 10/100 the MAC changes txd after the tx_clk rise instead
module pmmp_phy_end (
    input  wire logic                  i_link_clk,
    input  wire logic                  i_rst_b,
    input  wire pmmp_pkg::pmmp_speed_t i_speed,
    input  wire logic                  i_full_duplex,
    input  wire logic                  i_line_rx_valid,
    input  wire logic [7:0]            i_line_rx_data,
    input  wire logic                  i_line_rx_err,
    output logic                       o_line_rx_ready,
    output logic                       o_line_tx_valid,
    output logic [7:0]                 o_line_tx_data,
    output pmmp_pkg::pmmp_sym_t        o_line_tx_sym,
    input  wire logic                  i_mgmt_drive,
    input  wire logic                  i_mgmt_bit,
    output logic                       o_mgmt_bit,
    output logic                       o_mgmt_clk_rise,
    pmmp_if.phy                        link
);
    import pmmp_pkg::*;

    logic [7:0]  tx_div_q;
    logic        tx_clk_q;
    logic [7:0]  rx_div_q;
    logic        rx_clk_q;
    logic        tx_term;
    logic        rx_term;
    logic        tx_rise;
    logic        rx_fall;

    logic [12:0] pin_meta_q;
    logic [12:0] pin_sync_q;
    logic        gtx_prev_q;
    logic        mdc_prev_q;
    logic        s_gtx;
    logic        s_mdc;
    logic        s_mdio;
    logic        s_en;
    logic        s_er;
    logic [7:0]  s_txd;
    logic        gtx_rise;
    logic        tx_take;
    logic        er_allowed;

    logic        tx_act_q;
    logic        er_prev_q;
    logic        tx_valid_q;
    logic [7:0]  tx_data_q;
    pmmp_sym_t   tx_sym_q;

    logic [7:0]  rxd_q;
    logic        rx_dv_q;
    logic        rx_er_q;
    logic        crs_q;
    logic        col_q;
    logic        mdio_o_q;
    logic        mdio_oe_b_q;

    // Half period of a PHY-made clock for the current speed
    function automatic logic [7:0] half_cnt(input pmmp_speed_t s, input logic is_rx);
        case (s)
            PMMP_SPD_10: begin
                half_cnt = PMMP_HALF_10;
            end
            PMMP_SPD_1000: begin
                half_cnt = is_rx ? PMMP_HALF_1000 : PMMP_HALF_100;
            end
            default: begin
                half_cnt = PMMP_HALF_100;
            end
        endcase
    endfunction

    // Greater-or-equal so a speed change never strands the counter
    assign tx_term = (tx_div_q >= half_cnt(i_speed, 1'b0) - 8'h01);
    assign rx_term = (rx_div_q >= half_cnt(i_speed, 1'b1) - 8'h01);
    assign tx_rise = tx_term && !tx_clk_q;
    assign rx_fall = rx_term && rx_clk_q;

    // RQ6 free-running transmit clock
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_div_q <= 8'h00;
            tx_clk_q <= 1'b0;
        end else if (tx_term) begin
            tx_div_q <= 8'h00;
            tx_clk_q <= ~tx_clk_q;
        end else begin
            tx_div_q <= tx_div_q + 8'h01;
        end
    end

    // RQ13 receive clock per speed
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_div_q <= 8'h00;
            rx_clk_q <= 1'b0;
        end else if (rx_term) begin
            rx_div_q <= 8'h00;
            rx_clk_q <= ~rx_clk_q;
        end else begin
            rx_div_q <= rx_div_q + 8'h01;
        end
    end

    assign link.tx_clk = tx_clk_q;
    assign link.rx_clk = rx_clk_q;

    // Data and clock pins share one delay, so they stay aligned
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta_q <= 13'h0000;
            pin_sync_q <= 13'h0000;
        end else begin
            pin_meta_q <= {link.gtx_clk, link.mdc, link.mdio, link.tx_en, link.tx_er, link.txd};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign {s_gtx, s_mdc, s_mdio, s_en, s_er, s_txd} = pin_sync_q;

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gtx_prev_q <= 1'b0;
            mdc_prev_q <= 1'b0;
        end else begin
            gtx_prev_q <= s_gtx;
            mdc_prev_q <= s_mdc;
        end
    end

    // RQ9 gigabit capture follows the MAC clock
    assign gtx_rise = s_gtx && !gtx_prev_q;
    // RQ17 capture on active rising edge
    assign tx_take = (i_speed == PMMP_SPD_1000) ? gtx_rise : tx_rise;
    // RQ10 error ignored at 10 Mb/s
    assign er_allowed = s_er && (i_speed != PMMP_SPD_10);

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_act_q   <= 1'b0;
            er_prev_q  <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            tx_sym_q   <= PMMP_SYM_DATA;
        end else if (tx_take) begin
            tx_act_q   <= s_en;
            er_prev_q  <= s_en && er_allowed;
            // RQ8 accept only while enabled
            tx_valid_q <= s_en;
            // RQ7 lane width per mode
            tx_data_q  <= pmmp_lane(s_txd, i_speed);
            if (!er_allowed) begin
                tx_sym_q <= PMMP_SYM_DATA;
            end else if (i_speed == PMMP_SPD_1000) begin
                // RQ12 gigabit error code-group
                tx_sym_q <= PMMP_SYM_ERRGRP;
            end else begin
                // RQ11 invalid first, then halt
                tx_sym_q <= er_prev_q ? PMMP_SYM_HALT : PMMP_SYM_INVALID;
            end
        end else begin
            tx_valid_q <= 1'b0;
        end
    end

    assign o_line_tx_valid = tx_valid_q;
    assign o_line_tx_data  = tx_data_q;
    assign o_line_tx_sym   = tx_sym_q;

    // Line side is offered one word per receive clock period
    assign o_line_rx_ready = rx_fall;

    // RQ17 receive lines change on falling edge
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rxd_q   <= 8'h00;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
        end else if (rx_fall) begin
            // RQ14 lane width per mode
            rxd_q   <= i_line_rx_valid ? pmmp_lane(i_line_rx_data, i_speed) : 8'h00;
            // RQ15 valid qualifies each word
            rx_dv_q <= i_line_rx_valid;
            // RQ16 no receive error at 10 Mb/s
            rx_er_q <= i_line_rx_err && (i_speed != PMMP_SPD_10);
        end
    end

    assign link.rxd   = rxd_q;
    assign link.rx_dv = rx_dv_q;
    assign link.rx_er = rx_er_q;

    // Receive activity is the driven valid, transmit the captured enable
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else begin
            if (!i_full_duplex) begin
                // RQ3 either direction
                crs_q <= rx_dv_q || tx_act_q;
            end else begin
                // RQ4 receive only, gigabit held low
                crs_q <= rx_dv_q && (i_speed != PMMP_SPD_1000);
            end
            // RQ5 overlap in half duplex only
            col_q <= !i_full_duplex && rx_dv_q && tx_act_q;
        end
    end

    assign link.crs = crs_q;
    assign link.col = col_q;

    // RQ2 drive only on request, else release
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mdio_o_q    <= 1'b1;
            mdio_oe_b_q <= 1'b1;
        end else begin
            mdio_o_q    <= i_mgmt_bit;
            mdio_oe_b_q <= !i_mgmt_drive;
        end
    end

    assign link.phy_mdio_o    = mdio_o_q;
    assign link.phy_mdio_oe_b = mdio_oe_b_q;

    // RQ1 slow clock assumed, sampled not used as clock
    assign o_mgmt_clk_rise = s_mdc && !mdc_prev_q;
    assign o_mgmt_bit      = s_mdio;

endmodule

// [rtl/pmmp_pkg.sv]
// Shared constants, types and helpers for the MII/GMII port pair.
// Assumes both ends import this package; clock rates are scaled models.
package pmmp_pkg;

    typedef enum logic [1:0] {
        PMMP_SPD_10   = 2'b00,
        PMMP_SPD_100  = 2'b01,
        PMMP_SPD_1000 = 2'b10
    } pmmp_speed_t;

    typedef enum logic [1:0] {
        PMMP_SYM_DATA    = 2'b00,
        PMMP_SYM_INVALID = 2'b01,
        PMMP_SYM_HALT    = 2'b10,
        PMMP_SYM_ERRGRP  = 2'b11
    } pmmp_sym_t;

    // Reference clock and management clock timing
    localparam int unsigned PMMP_REF_PERIOD_NS  = 100;
    localparam int unsigned PMMP_MDC_MAX_KHZ    = 2500;
    localparam int unsigned PMMP_MDC_MIN_PER_NS = 1000000 / PMMP_MDC_MAX_KHZ;
    localparam int unsigned PMMP_MDC_CYC        =
        (PMMP_MDC_MIN_PER_NS + PMMP_REF_PERIOD_NS - 1) / PMMP_REF_PERIOD_NS;
    localparam logic [7:0]  PMMP_MDC_HALF       = 8'(PMMP_MDC_CYC / 2);

    // Half periods of the scaled interface clocks, in source clock cycles
    localparam logic [7:0]  PMMP_HALF_1000      = 8'h04;
    localparam logic [7:0]  PMMP_HALF_100       = 8'h08;
    localparam logic [7:0]  PMMP_HALF_10        = 8'h50;
    localparam logic [7:0]  PMMP_GTX_HALF       = 8'h08;

    localparam logic [7:0]  PMMP_NIBBLE_MASK    = 8'h0F;
    localparam logic [7:0]  PMMP_BYTE_MASK      = 8'hFF;

    // Upper lines carry nothing outside gigabit mode
    function automatic logic [7:0] pmmp_lane(input logic [7:0] d, input pmmp_speed_t s);
        pmmp_lane = d & ((s == PMMP_SPD_1000) ? PMMP_BYTE_MASK : PMMP_NIBBLE_MASK);
    endfunction

endpackage

// [test/pmmp_port_monitor.sv]
// Pin-level checks between the PHY end and the MAC end.
// Assumes one shared active-low reset; speed and duplex change only in reset.
module pmmp_port_monitor (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_link_clk,
    input  wire logic                  i_rst_b,
    input  wire pmmp_pkg::pmmp_speed_t i_speed,
    input  wire logic                  i_full_duplex,
    input  wire logic                  tx_clk,
    input  wire logic                  gtx_clk,
    input  wire logic                  rx_clk,
    input  wire logic [7:0]            txd,
    input  wire logic                  tx_en,
    input  wire logic                  tx_er,
    input  wire logic [7:0]            rxd,
    input  wire logic                  rx_dv,
    input  wire logic                  rx_er,
    input  wire logic                  crs,
    input  wire logic                  col,
    input  wire logic                  mdc
);
    timeunit 1ns;
    timeprecision 100ps;
    import pmmp_pkg::*;

    // Clock high for eight samples, then low
    sequence s_half8(logic c);
        c[*8] ##1 !c;
    endsequence

    a_col_full_low: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        i_full_duplex |-> !col) else $error("collision in full duplex");
    a_crs_gig_full: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        (i_full_duplex && i_speed == PMMP_SPD_1000) |-> !crs) else $error("carrier in gig full");
    a_rx_idle_zero: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        !rx_dv |-> (rxd == 8'h00)) else $error("receive data without valid");
    a_rx_lane_width: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        (i_speed != PMMP_SPD_1000) |-> (rxd[7:4] == 4'h0)) else $error("upper receive lines");
    a_rx_err_slow: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        (i_speed == PMMP_SPD_10) |-> !rx_er) else $error("receive error at 10");
    a_rx_edge_fall: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        ($changed(rxd) || $changed(rx_dv) || $changed(rx_er)) |-> $fell(rx_clk))
        else $error("receive pins moved off the falling clock");
    a_rx_clk_half: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        ($rose(rx_clk) && i_speed == PMMP_SPD_100) |-> s_half8(rx_clk))
        else $error("receive clock half period");
    a_tx_clk_half: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        ($rose(tx_clk) && i_speed != PMMP_SPD_10) |-> s_half8(tx_clk))
        else $error("transmit clock half period");
    a_tx_clk_slow: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        ($rose(tx_clk) && i_speed == PMMP_SPD_10) |-> ##80 $fell(tx_clk))
        else $error("slow transmit clock half period");
    a_gtx_clk_half: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(gtx_clk) |-> s_half8(gtx_clk)) else $error("gigabit clock half period");
    a_mdc_max_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(mdc) |-> mdc[*2] ##1 !mdc) else $error("management clock too fast");
    a_tx_idle_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !tx_en |-> (txd == 8'h00 && !tx_er)) else $error("transmit pins without enable");
    a_tx_lane_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_speed != PMMP_SPD_1000) |-> (txd[7:4] == 4'h0)) else $error("upper transmit lines");
    a_tx_err_slow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_speed == PMMP_SPD_10) |-> !tx_er) else $error("transmit error at 10");
endmodule

// [test/tb_phy_mii_gmii_mac_port.sv]
// Bench joining the PHY end and MAC end through the pin interface.
// Assumes speed and duplex are set only while reset is held.
module tb_phy_mii_gmii_mac_port;
    timeunit 1ns;
    timeprecision 100ps;
    import pmmp_pkg::*;

    logic        i_ref_clk, i_link_clk, i_rst_b, full_duplex, seen_crs, seen_col;
    pmmp_speed_t speed;
    logic        lrx_valid, lrx_err, lrx_ready, ltx_valid, tx_valid, tx_err, tx_ready;
    logic [7:0]  lrx_data, ltx_data, tx_data, rx_data;
    pmmp_sym_t   ltx_sym;
    logic        rx_valid, rx_err, crs, col, mgmt_rise;
    logic        phy_drv, phy_bit, phy_out, mac_drv, mac_bit, mac_out;
    logic [8:0]  rx_q[$];
    logic [9:0]  tx_q[$];
    logic [8:0]  exp9;
    logic [9:0]  exp10;
    int          fails, checks, cyc, rises;

    pmmp_if lnk();
    pmmp_phy_end u_pmmp_phy_end (.i_link_clk(i_link_clk), .i_rst_b(i_rst_b), .i_speed(speed),
        .i_full_duplex(full_duplex), .i_line_rx_valid(lrx_valid), .i_line_rx_data(lrx_data),
        .i_line_rx_err(lrx_err), .o_line_rx_ready(lrx_ready), .o_line_tx_valid(ltx_valid),
        .o_line_tx_data(ltx_data), .o_line_tx_sym(ltx_sym), .i_mgmt_drive(phy_drv),
        .i_mgmt_bit(phy_bit), .o_mgmt_bit(phy_out), .o_mgmt_clk_rise(mgmt_rise), .link(lnk));
    pmmp_mac_end u_pmmp_mac_end (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_speed(speed),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_err(tx_err), .o_tx_ready(tx_ready),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_err(rx_err), .o_crs(crs),
        .o_col(col), .i_mgmt_drive(mac_drv), .i_mgmt_bit(mac_bit), .o_mgmt_bit(mac_out),
        .link(lnk));
    pmmp_port_monitor u_pmmp_port_monitor (.i_ref_clk(i_ref_clk), .i_link_clk(i_link_clk),
        .i_rst_b(i_rst_b), .i_speed(speed), .i_full_duplex(full_duplex), .tx_clk(lnk.tx_clk),
        .gtx_clk(lnk.gtx_clk), .rx_clk(lnk.rx_clk), .txd(lnk.txd), .tx_en(lnk.tx_en),
        .tx_er(lnk.tx_er), .rxd(lnk.rxd), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er),
        .crs(lnk.crs), .col(lnk.col), .mdc(lnk.mdc));

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    // Link clock offset so the two domains never line up
    initial begin
        i_link_clk = 1'b0;
        #17;
        forever #62.5 i_link_clk = ~i_link_clk;
    end

    function automatic logic [7:0] exp_lane(input logic [7:0] d);
        return (speed == PMMP_SPD_1000) ? d : (d & 8'h0F);
    endfunction

    function automatic pmmp_sym_t exp_sym(input logic err, input logic prev);
        if (!err || speed == PMMP_SPD_10) return PMMP_SYM_DATA;
        if (speed == PMMP_SPD_1000) return PMMP_SYM_ERRGRP;
        return prev ? PMMP_SYM_HALT : PMMP_SYM_INVALID;
    endfunction

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // First word all ones, so a missing nibble mask shows
    task automatic rx_burst(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge i_link_clk);
            lrx_valid = 1'b1;
            lrx_data = (i == 0) ? 8'hFF : 8'($urandom);
            lrx_err = (i == 0) || ($urandom % 4 == 0);
            #20;
            while (lrx_ready !== 1'b1 && k < 400) begin
                @(negedge i_link_clk);
                #20;
                k++;
            end
            @(posedge i_link_clk);
            rx_q.push_back({lrx_err && speed != PMMP_SPD_10, exp_lane(lrx_data)});
        end
        @(negedge i_link_clk);
        lrx_valid = 1'b0;
    endtask

    // Words 1 and 2 errored back to back for the halt case
    task automatic tx_burst(input int n);
        int k;
        logic prev;
        prev = 1'b0;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge i_ref_clk);
            tx_valid = 1'b1;
            tx_data = (i == 0) ? 8'hA5 : 8'($urandom);
            tx_err = (i == 1) || (i == 2) || ($urandom % 5 == 0);
            #20;
            while (tx_ready !== 1'b1 && k < 600) begin
                @(negedge i_ref_clk);
                #20;
                k++;
            end
            @(posedge i_ref_clk);
            tx_q.push_back({exp_sym(tx_err, prev), exp_lane(tx_data)});
            prev = tx_err && speed == PMMP_SPD_100;
        end
        @(negedge i_ref_clk);
        tx_valid = 1'b0;
    endtask

    // Quiet tail lets carrier and collision settle before flags clear
    task automatic drain();
        int k;
        k = 0;
        while ((rx_q.size() != 0 || tx_q.size() != 0) && k < 3000) begin
            @(posedge i_ref_clk);
            k++;
        end
        repeat (600) @(posedge i_ref_clk);
        check_flag(rx_q.size() == 0 && tx_q.size() == 0, 1'b1, "words lost");
    endtask

    task automatic mgmt_test();
        for (int b = 0; b < 2; b++) begin
            @(negedge i_ref_clk);
            mac_drv = 1'b1;
            mac_bit = b[0];
            repeat (8) @(negedge i_link_clk);
            check_flag(phy_out, b[0], "mdio to phy");
            @(negedge i_ref_clk) mac_drv = 1'b0;
            repeat (4) @(negedge i_link_clk);
            phy_drv = 1'b1;
            phy_bit = ~b[0];
            repeat (8) @(negedge i_ref_clk);
            check_flag(mac_out, ~b[0], "mdio to mac");
            @(negedge i_link_clk) phy_drv = 1'b0;
        end
        rises = 0;
        repeat (400) @(posedge i_ref_clk);
        check_flag(phy_out, 1'b1, "mdio released");
        check_flag(rises >= 99 && rises <= 101, 1'b1, "mgmt clock rate");
    endtask

    always @(negedge i_ref_clk) begin
        if (rx_valid === 1'b1) begin
            exp9 = (rx_q.size() != 0) ? rx_q.pop_front() : 9'h1FF;
            check_vec(rx_data, exp9[7:0], "rx data");
            check_flag(rx_err, exp9[8], "rx err");
        end
        if (crs === 1'b1) seen_crs = 1'b1;
        if (col === 1'b1) seen_col = 1'b1;
    end

    always @(negedge i_link_clk) begin
        if (mgmt_rise === 1'b1) rises++;
        if (ltx_valid === 1'b1) begin
            exp10 = (tx_q.size() != 0) ? tx_q.pop_front() : 10'h3FF;
            check_vec(8'(ltx_sym), 8'(exp10[9:8]), "tx sym");
            if (exp10[9:8] == 2'b00) check_vec(ltx_data, exp10[7:0], "tx data");
        end
    end

    // Hang guard, well above the expected run
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            check_flag(1'b0, 1'b1, "run timed out");
            complete_run();
        end
    end

    initial begin
        {lrx_valid, lrx_err, lrx_data, tx_valid, tx_err, tx_data} = '0;
        {phy_drv, phy_bit, mac_drv, mac_bit, full_duplex, seen_crs, seen_col} = '0;
        void'($urandom(78));
        for (int c = 0; c < 6; c++) begin
            i_rst_b = 1'b0;
            speed = pmmp_speed_t'(c / 2);
            full_duplex = c[0];
            repeat (3) @(posedge i_ref_clk);
            @(negedge i_ref_clk) i_rst_b = 1'b1;
            rx_q.delete();
            tx_q.delete();
            seen_crs = 1'b0;
            seen_col = 1'b0;
            tx_burst(6);
            drain();
            check_flag(seen_crs, !full_duplex, "crs on tx only");
            seen_crs = 1'b0;
            seen_col = 1'b0;
            fork
                rx_burst(6);
                tx_burst(6);
            join
            drain();
            check_flag(seen_crs, !(full_duplex && speed == PMMP_SPD_1000), "crs on rx");
            check_flag(seen_col, !full_duplex, "collision");
            mgmt_test();
            $display("test speed %0d duplex %0d done", c / 2, full_duplex);
        end
        complete_run();
    end
endmodule
